// file: design/slsu_pkg.sv
/*
 * package of the single load/store unit: register offsets, instruction
 * field positions, reset values, state codes and the memory-side carrier.
 * assumes a 32-bit wishbone register bus and a 32-bit data memory bus.
 */
package slsu_pkg;
	// register byte offsets on the wishbone bus
	localparam logic [5:0] REG_INSTR   = 6'h00; // transfer instruction word
	localparam logic [5:0] REG_BASE    = 6'h04; // base_register contents
	localparam logic [5:0] REG_OFFSET  = 6'h08; // offset_register contents
	localparam logic [5:0] REG_SOURCE  = 6'h0C; // store source contents
	localparam logic [5:0] REG_PC      = 6'h10; // current instruction address
	localparam logic [5:0] REG_FLAGS   = 6'h14; // processor_status_flags
	localparam logic [5:0] REG_CTRL    = 6'h18; // start bit only; status clears by writing REG_STATUS
	localparam logic [5:0] REG_STATUS  = 6'h1C; // busy and sticky results
	localparam logic [5:0] REG_RESULT  = 6'h20; // load result for destination
	localparam logic [5:0] REG_NEWBASE = 6'h24; // written-back base value
	localparam logic [5:0] REG_XADDR   = 6'h28; // transfer address used
	// instruction field positions
	localparam int F_IMM_LO  = 0;  // 12-bit immediate offset
	localparam int F_RM_LO   = 0;  // offset register index
	localparam int F_STYP_LO = 5;  // shift type
	localparam int F_SAMT_LO = 7;  // immediate shift amount
	localparam int F_RD_LO   = 12; // source / destination index
	localparam int F_RN_LO   = 16; // base register index
	localparam int F_LOAD    = 20; // 1 load, 0 store
	localparam int F_WB      = 21; // write-back bit
	localparam int F_BYTE    = 22; // byte bit
	localparam int F_UP      = 23; // up/down bit
	localparam int F_PRE     = 24; // pre/post bit
	localparam int F_REGOFF  = 25; // 1 register offset, 0 immediate
	// processor_status_flags layout (inside a program_counter_register word)
	localparam int F_PC_LO   = 2;  // program counter bits 25..2
	localparam int F_CARRY   = 29; // carry flag, used by rotate-extend
	localparam int F_EXC_LO  = 26; // address bits that must be zero
	localparam logic [31:0] FLAG_MASK = 32'hFC000003; // flags and mode bits
	localparam logic [31:0] PC_MASK   = 32'h03FFFFFC; // program counter bits
	localparam logic [1:0]  MODE_USER = 2'h0;         // user mode code
	localparam logic [3:0]  PC_INDEX  = 4'hF;         // program_counter_register
	localparam logic [31:0] PC_AHEAD_BASE  = 32'h00000008; // read-ahead as base
	localparam logic [31:0] PC_AHEAD_STORE = 32'h0000000C; // read-ahead as store
	// shift type codes
	localparam logic [1:0] SH_LSL = 2'h0;
	localparam logic [1:0] SH_LSR = 2'h1;
	localparam logic [1:0] SH_ASR = 2'h2;
	localparam logic [1:0] SH_ROR = 2'h3;
	// control and status bits
	localparam int C_START  = 0; // write 1 to start a transfer
	localparam int S_BUSY   = 0; // transfer in progress
	localparam int S_DONE   = 1; // transfer completed, sticky
	localparam int S_ADDREX = 2; // address exception trap, sticky
	localparam int S_ABORT  = 3; // data abort trap, sticky
	localparam int S_WBACK  = 4; // base was written back, sticky
	localparam int S_PCLOAD = 5; // load targeted program counter, sticky
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_CALC  = 4'h2,
		ST_XFER  = 4'h4,
		ST_CLOSE = 4'h8
	} slsu_state_t;
	// memory-side request carrier
	typedef struct packed {
		logic [31:0] addr;    // transfer address
		logic [31:0] wdata;   // store data, all lanes
		logic        req;     // transfer request, level
		logic        we;      // 1 store, 0 load
		logic        byte_en; // 1 byte transfer, 0 word
		logic        tran_n;  // user-translation, active low
	} slsu_mem_req_t;
endpackage

// file: design/slsu_top.sv
/*
 * single load/store unit: address generation, indexing, write-back,
 * byte lane steering, program counter handling and trap detection.
 * assumes a classic wishbone master for the registers and a memory
 * system that answers a held request with mem_done and may raise
 * abort_request; both of those arrive from outside the clock domain.
 */
// The address map and register access over Wishbone were chosen for this implementation.
// Summary of operation
// - offset is 12-bit immediate or shifted register
// - up bit adds offset, else subtracts
// - pre bit offsets before transfer, else after
// - pre-indexed writes back only with write-back bit
// - post-indexed always writes back modified base
// - post-indexed privileged write-back drives translation low
// - register offset shifts by immediate amount only
// - byte bit selects byte, else word transfer
// - little-endian, low byte at lowest address
// - byte load picks lane, zero-fills upper bits
// - byte store repeats low byte on lanes
// - unaligned word load rotates addressed byte low
// - transfers never change status flags
// - pc as base: pc plus eight, no flags
// - pc as offset register includes flags
// - storing pc: pc plus twelve with flags
// - load into pc keeps status flags
// - high address bits set trap, no transfer
// - only actual transfer address is checked
// - abort blocks state change, takes data abort
`timescale 1ns/1ps
module slsu_top (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [5:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// memory side
	output slsu_pkg::slsu_mem_req_t     mem_o,
	input  wire logic [31:0]            mem_rdata,
	input  wire logic                   mem_done,
	input  wire logic                   abort_request
);
	// software-loaded operand registers
	logic [31:0] instr,    next_instr;    // transfer instruction
	logic [31:0] base_val, next_base_val; // base_register contents
	logic [31:0] off_val,  next_off_val;  // offset_register contents
	logic [31:0] src_val,  next_src_val;  // store source contents
	logic [31:0] pc_val,   next_pc_val;   // instruction address
	logic [31:0] flags,    next_flags;    // processor_status_flags
	// results and status
	logic [31:0] result,   next_result;   // load result
	logic [31:0] new_base, next_new_base; // written-back base
	logic [31:0] xaddr,    next_xaddr;    // address used
	logic [5:0]  status,   next_status;   // status bits
	logic        start_req;               // start written this cycle
	logic [5:0]  status_clr;              // status bits written 1
	// bus answer
	logic [31:0] next_wb_dat;
	logic        next_wb_ack;
	// sequencer
	slsu_pkg::slsu_state_t   state, next_state;
	slsu_pkg::slsu_mem_req_t next_mem;
	logic [31:0] calc_addr,  next_calc_addr; // held transfer address
	logic [31:0] calc_base,  next_calc_base; // held modified base
	// synchronisers for outside inputs
	logic [31:0] rdata_s1, rdata_s2;
	logic        done_s1,  done_s2;
	logic        abort_s1, abort_s2;
	// combinational address generation
	logic [31:0] pc_base;    // pc read-ahead as base
	logic [31:0] pc_store;   // pc read-ahead as store data
	logic [31:0] base_op;    // effective base operand
	logic [31:0] rm_op;      // effective offset register operand
	logic [31:0] offset_op;  // final offset
	logic [31:0] modified;   // base after offset
	logic [31:0] xfer_addr;  // address used for the transfer
	logic [31:0] store_data; // source after pc substitution
	logic [31:0] load_data;  // steered load data
	logic [4:0]  rot_bits;   // rotate amount in bits
	logic        wb_hit;     // valid bus cycle not yet acked
	logic        do_wback;   // base write-back wanted

	// merges byte-enabled write data into a register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = wdat[8*i +: 8];
			end
		end
		return res;
	endfunction

	// two-flop synchronisers on memory-side inputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_s1 <= slsu_pkg::RESET_WORD;
			rdata_s2 <= slsu_pkg::RESET_WORD;
			done_s1  <= 1'b0;
			done_s2  <= 1'b0;
			abort_s1 <= 1'b0;
			abort_s2 <= 1'b0;
		end else begin
			rdata_s1 <= mem_rdata;
			rdata_s2 <= rdata_s1;
			done_s1  <= mem_done;
			done_s2  <= done_s1;
			abort_s1 <= abort_request;
			abort_s2 <= abort_s1;
		end
	end

	// address generation and operand selection
	always_comb begin
		// pc read-ahead values, kept to the 26-bit address space
		pc_base  = (pc_val + slsu_pkg::PC_AHEAD_BASE) & slsu_pkg::PC_MASK;
		pc_store = (pc_val + slsu_pkg::PC_AHEAD_STORE) & slsu_pkg::PC_MASK;
		// base from pc carries no flags
		if (instr[slsu_pkg::F_RN_LO +: 4] == slsu_pkg::PC_INDEX) begin
			base_op = pc_base;
		end else begin
			base_op = base_val;
		end
		// offset register from pc carries flags
		if (instr[slsu_pkg::F_RM_LO +: 4] == slsu_pkg::PC_INDEX) begin
			rm_op = pc_base | (flags & slsu_pkg::FLAG_MASK);
		end else begin
			rm_op = off_val;
		end
		// offset: immediate or immediate-shifted register only
		if (!instr[slsu_pkg::F_REGOFF]) begin
			offset_op = {20'h00000, instr[slsu_pkg::F_IMM_LO +: 12]};
		end else begin
			// shift amount always from the instruction field
			case (instr[slsu_pkg::F_STYP_LO +: 2])
				slsu_pkg::SH_LSL: offset_op = rm_op << instr[slsu_pkg::F_SAMT_LO +: 5];
				slsu_pkg::SH_LSR: begin
					// zero amount encodes a shift of 32
					if (instr[slsu_pkg::F_SAMT_LO +: 5] == 5'h00) begin
						offset_op = 32'h00000000;
					end else begin
						offset_op = rm_op >> instr[slsu_pkg::F_SAMT_LO +: 5];
					end
				end
				slsu_pkg::SH_ASR: begin
					// zero amount encodes a shift of 32
					if (instr[slsu_pkg::F_SAMT_LO +: 5] == 5'h00) begin
						offset_op = {32{rm_op[31]}};
					end else begin
						offset_op = 32'($signed(rm_op) >>> instr[slsu_pkg::F_SAMT_LO +: 5]);
					end
				end
				default: begin
					// zero amount is rotate-extend through carry
					if (instr[slsu_pkg::F_SAMT_LO +: 5] == 5'h00) begin
						offset_op = {flags[slsu_pkg::F_CARRY], rm_op[31:1]};
					end else begin
						offset_op = (rm_op >> instr[slsu_pkg::F_SAMT_LO +: 5])
							| (rm_op << (6'd32 - {1'b0, instr[slsu_pkg::F_SAMT_LO +: 5]}));
					end
				end
			endcase
		end
		// add or subtract offset
		if (instr[slsu_pkg::F_UP]) begin
			modified = base_op + offset_op;
		end else begin
			modified = base_op - offset_op;
		end
		// pre-indexed uses modified, post-indexed the raw base
		xfer_addr = instr[slsu_pkg::F_PRE] ? modified : base_op;
		// write-back: pre only with bit set, post always
		do_wback = instr[slsu_pkg::F_PRE] ? instr[slsu_pkg::F_WB] : 1'b1;
		// store of pc sends pc plus twelve with flags
		if (instr[slsu_pkg::F_RD_LO +: 4] == slsu_pkg::PC_INDEX) begin
			store_data = pc_store | (flags & slsu_pkg::FLAG_MASK);
		end else begin
			store_data = src_val;
		end
		// low address bits choose lane and rotation
		rot_bits = {calc_addr[1:0], 3'h0};
		if (instr[slsu_pkg::F_BYTE]) begin
			load_data = {24'h000000, rdata_s2[rot_bits +: 8]};
		end else begin
			load_data = (rdata_s2 >> rot_bits) | (rdata_s2 << (6'd32 - {1'b0, rot_bits}));
		end
	end

	// wishbone decode
	always_comb begin
		wb_hit      = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_wb_ack = wb_hit;
		next_wb_dat = slsu_pkg::RESET_WORD;
		start_req   = 1'b0;
		status_clr  = 6'h00;
		next_instr    = instr;
		next_base_val = base_val;
		next_off_val  = off_val;
		next_src_val  = src_val;
		next_pc_val   = pc_val;
		next_flags    = flags;
		if (wb_hit && wb_we_i) begin
			// writes; unmapped addresses are acked and ignored
			case (wb_adr_i)
				slsu_pkg::REG_INSTR:  next_instr    = merge(instr, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_BASE:   next_base_val = merge(base_val, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_OFFSET: next_off_val  = merge(off_val, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_SOURCE: next_src_val  = merge(src_val, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_PC:     next_pc_val   = merge(pc_val, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_FLAGS:  next_flags    = merge(flags, wb_dat_i, wb_sel_i);
				slsu_pkg::REG_CTRL:   start_req     = wb_sel_i[0] && wb_dat_i[slsu_pkg::C_START];
				slsu_pkg::REG_STATUS: status_clr    = wb_sel_i[0] ? wb_dat_i[5:0] : 6'h00;
				default: ;
			endcase
		end else if (wb_hit) begin
			// reads; unmapped addresses read zero
			case (wb_adr_i)
				slsu_pkg::REG_INSTR:   next_wb_dat = instr;
				slsu_pkg::REG_BASE:    next_wb_dat = base_val;
				slsu_pkg::REG_OFFSET:  next_wb_dat = off_val;
				slsu_pkg::REG_SOURCE:  next_wb_dat = src_val;
				slsu_pkg::REG_PC:      next_wb_dat = pc_val;
				slsu_pkg::REG_FLAGS:   next_wb_dat = flags;
				slsu_pkg::REG_STATUS:  next_wb_dat = {26'h0000000, status};
				slsu_pkg::REG_RESULT:  next_wb_dat = result;
				slsu_pkg::REG_NEWBASE: next_wb_dat = new_base;
				slsu_pkg::REG_XADDR:   next_wb_dat = xaddr;
				default:               next_wb_dat = slsu_pkg::RESET_WORD;
			endcase
		end
		// operands are frozen while a transfer runs
		if (state != slsu_pkg::ST_IDLE) begin
			next_instr    = instr;
			next_base_val = base_val;
			next_off_val  = off_val;
			next_src_val  = src_val;
			next_pc_val   = pc_val;
			next_flags    = flags;
		end
	end

	// transfer sequencer
	always_comb begin
		next_state     = state;
		next_mem       = mem_o;
		next_calc_addr = calc_addr;
		next_calc_base = calc_base;
		next_result    = result;
		next_new_base  = new_base;
		next_xaddr     = xaddr;
		// software clears sticky bits; hardware sets below and wins
		next_status    = status & ~status_clr;
		case (state)
			slsu_pkg::ST_IDLE: begin
				// start ignored unless idle
				if (start_req) begin
					next_status = 6'h00;
					next_status[slsu_pkg::S_BUSY] = 1'b1;
					next_state = slsu_pkg::ST_CALC;
				end
			end
			slsu_pkg::ST_CALC: begin
				next_calc_addr = xfer_addr;
				next_calc_base = modified;
				next_xaddr     = xfer_addr;
				// check only the address actually used
				if (|xfer_addr[31:slsu_pkg::F_EXC_LO]) begin
					next_status[slsu_pkg::S_ADDREX] = 1'b1;
					next_state = slsu_pkg::ST_CLOSE;
				end else begin
					next_mem.addr    = xfer_addr;
					next_mem.we      = !instr[slsu_pkg::F_LOAD];
					next_mem.byte_en = instr[slsu_pkg::F_BYTE];
					// byte store repeats the low byte on every lane
					next_mem.wdata   = instr[slsu_pkg::F_BYTE] ?
						{4{store_data[7:0]}} : store_data;
					next_mem.tran_n  = !(!instr[slsu_pkg::F_PRE] && instr[slsu_pkg::F_WB]
						&& flags[1:0] != slsu_pkg::MODE_USER);
					next_mem.req     = 1'b1;
					next_state = slsu_pkg::ST_XFER;
				end
			end
			slsu_pkg::ST_XFER: begin
				// abort blocks all result and base updates
				if (abort_s2) begin
					next_status[slsu_pkg::S_ABORT] = 1'b1;
					next_mem.req    = 1'b0;
					next_mem.tran_n = 1'b1;
					next_state = slsu_pkg::ST_CLOSE;
				end else if (done_s2) begin
					next_mem.req    = 1'b0;
					next_mem.tran_n = 1'b1;
					if (instr[slsu_pkg::F_LOAD]) begin
						if (instr[slsu_pkg::F_RD_LO +: 4] == slsu_pkg::PC_INDEX) begin
							// pc load keeps current flags and mode
							next_result = (load_data & slsu_pkg::PC_MASK)
								| (flags & slsu_pkg::FLAG_MASK);
							next_status[slsu_pkg::S_PCLOAD] = 1'b1;
						end else begin
							next_result = load_data;
						end
					end
					if (do_wback) begin
						next_new_base = calc_base;
						next_status[slsu_pkg::S_WBACK] = 1'b1;
					end
					next_status[slsu_pkg::S_DONE] = 1'b1;
					next_state = slsu_pkg::ST_CLOSE;
				end
			end
			slsu_pkg::ST_CLOSE: begin
				// wait for memory to drop its answers before idling
				if (!done_s2 && !abort_s2) begin
					next_status[slsu_pkg::S_BUSY] = 1'b0;
					next_state = slsu_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state   = slsu_pkg::ST_IDLE;
				next_mem.req = 1'b0;
			end
		endcase
	end

	// register all state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			instr     <= slsu_pkg::RESET_WORD;
			base_val  <= slsu_pkg::RESET_WORD;
			off_val   <= slsu_pkg::RESET_WORD;
			src_val   <= slsu_pkg::RESET_WORD;
			pc_val    <= slsu_pkg::RESET_WORD;
			flags     <= slsu_pkg::RESET_WORD;
			result    <= slsu_pkg::RESET_WORD;
			new_base  <= slsu_pkg::RESET_WORD;
			xaddr     <= slsu_pkg::RESET_WORD;
			calc_addr <= slsu_pkg::RESET_WORD;
			calc_base <= slsu_pkg::RESET_WORD;
			status    <= 6'h00;
			state     <= slsu_pkg::ST_IDLE;
			mem_o     <= '{addr: 32'h00000000, wdata: 32'h00000000, req: 1'b0,
				we: 1'b0, byte_en: 1'b0, tran_n: 1'b1};
			wb_dat_o  <= slsu_pkg::RESET_WORD;
			wb_ack_o  <= 1'b0;
		end else begin
			instr     <= next_instr;
			base_val  <= next_base_val;
			off_val   <= next_off_val;
			src_val   <= next_src_val;
			pc_val    <= next_pc_val;
			flags     <= next_flags;
			result    <= next_result;
			new_base  <= next_new_base;
			xaddr     <= next_xaddr;
			calc_addr <= next_calc_addr;
			calc_base <= next_calc_base;
			status    <= next_status;
			state     <= next_state;
			mem_o     <= next_mem;
			wb_dat_o  <= next_wb_dat;
			wb_ack_o  <= next_wb_ack;
		end
	end
endmodule

// file: verification/slsu_sva.sv
/*
 * port checker of the load/store unit: bus answer, request framing,
 * lane copies, legal addresses and the translation pin.
 * assumes a bind onto slsu_top with the port names unchanged.
 */
`timescale 1ns/1ps
module slsu_sva (
	input wire logic                    sys_clk,
	input wire logic                    rst,
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_ack_o,
	input wire slsu_pkg::slsu_mem_req_t mem_o,
	input wire logic                    mem_done,
	input wire logic                    abort_request
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// a taken request is answered on the next edge
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	// request fields stand while the request is up
	a_req_frozen: assert property (mem_o.req && $past(mem_o.req) |-> mem_o == $past(mem_o))
		else $error("memory request changed while held");
	a_req_release: assert property ($rose(mem_done || abort_request) && mem_o.req
		|-> ##[1:4] !mem_o.req)
		else $error("memory request not dropped after answer");
	a_addr_legal: assert property (mem_o.req |-> mem_o.addr[31:26] == 6'h00)
		else $error("request raised at an illegal address");
	a_byte_copies: assert property (mem_o.req && mem_o.we && mem_o.byte_en
		|-> mem_o.wdata == {4{mem_o.wdata[7:0]}})
		else $error("byte store lanes differ");
	a_tran_framed: assert property (!mem_o.req |-> mem_o.tran_n)
		else $error("translation pin low outside a transfer");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |-> !mem_o.req && mem_o.tran_n && !wb_ack_o)
		else $error("outputs active during reset");
endmodule

// file: verification/slsu_mem_model.sv
/*
 * far-side memory: 64 words, answers a held request after lat cycles
 * or refuses it with abort when told to.
 * assumes the unit holds its request until the answer is seen.
 */
`timescale 1ns/1ps
module slsu_mem_model (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire slsu_pkg::slsu_mem_req_t mem_o,
	input  wire logic                    abort_en,
	input  wire logic [1:0]              lat,
	output logic [31:0]                  mem_rdata,
	output logic                         mem_done,
	output logic                         abort_request
);
	logic [31:0] words [64]; // byte at address a holds a
	int          cnt;        // cycles waited
	logic [5:0]  ix;         // word index
	logic [4:0]  ln;         // lane bit offset
	assign ix = mem_o.addr[7:2];
	assign ln = {mem_o.addr[1:0], 3'h0};
	// low byte at the lowest address
	initial for (int i = 0; i < 64; i++) words[i] = 32'h03020100 + i * 32'h04040404;
	// answer a held request, drop once it falls; released data turns over
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mem_done <= 1'b0;
			abort_request <= 1'b0;
			mem_rdata <= 32'h0;
			cnt <= 0;
		end else if (!mem_o.req) begin
			if (mem_done || abort_request) mem_rdata <= ~mem_rdata;
			mem_done <= 1'b0;
			abort_request <= 1'b0;
			cnt <= 0;
		end else if (!mem_done && !abort_request) begin
			cnt <= cnt + 1;
			if (cnt >= lat) begin
				if (abort_en) abort_request <= 1'b1;
				else begin
					mem_done <= 1'b1;
					mem_rdata <= words[ix];
					if (mem_o.we && mem_o.byte_en) words[ix][ln +: 8] <= mem_o.wdata[ln +: 8];
					else if (mem_o.we) words[ix] <= mem_o.wdata;
				end
			end
		end
	end
endmodule

// file: verification/testbench.sv
/*
 * bench of the load/store unit: wishbone tasks and transfer sequences.
 * assumes slsu_top, the memory model and the checker compiled before.
 */
`timescale 1ns/1ps
module testbench;
	logic                    sys_clk = 1'b0;  // 10 MHz clock
	logic                    rst = 1'b0;      // async reset
	logic                    cyc = 1'b0;      // wishbone cycle
	logic                    stb = 1'b0;      // wishbone strobe
	logic                    we = 1'b0;       // write select
	logic [5:0]              adr = 6'h00;     // register offset
	logic [3:0]              sel = 4'hF;      // byte enables
	logic [31:0]             dat = 32'h0;     // write data
	logic [31:0]             wb_dat_o;        // read data
	logic                    wb_ack_o;        // bus answer
	slsu_pkg::slsu_mem_req_t mem_o;           // memory request
	logic [31:0]             mem_rdata;       // load data
	logic                    mem_done;        // memory answer
	logic                    abort_request;   // memory refusal
	logic                    abort_en = 1'b0; // model told to abort
	logic [1:0]              lat = 2'h0;      // model wait cycles
	logic                    req_q = 1'b0;    // request last cycle
	logic                    tran_low;        // translation seen low
	logic [31:0]             rdat;            // last read value
	int                      n_req;           // requests raised
	int                      mismatches = 0;  // failed compares
	int                      n_tests = 0;     // compares made
	always #50 sys_clk = ~sys_clk;
	slsu_top DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_done(mem_done),
		.abort_request(abort_request));
	slsu_mem_model mem (.sys_clk(sys_clk), .rst(rst), .mem_o(mem_o), .abort_en(abort_en),
		.lat(lat), .mem_rdata(mem_rdata), .mem_done(mem_done), .abort_request(abort_request));
	// count raised requests, note the translation pin
	always @(posedge sys_clk) begin
		req_q <= mem_o.req;
		if (mem_o.req && !req_q) n_req++;
		if (mem_o.req && !mem_o.tran_n) tran_low = 1'b1;
	end
	// instruction word from mode bits {r,p,u,b,w,l}
	function automatic logic [31:0] mk(input logic [5:0] m, input logic [3:0] rn, rd,
		input logic [11:0] off);
		return {6'h00, m, rn, rd, off};
	endfunction
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// read a register, compare the masked bits
	task automatic rdc(input logic [5:0] a, input logic [31:0] exp, msk);
		wb(1'b0, a, 32'h0, 4'hF);
		cmp(rdat & msk, exp & msk);
	endtask
	// load operands, start, poll until busy clears
	task automatic xfer(input logic [31:0] ins, b, o = 32'h0, f = 32'h0, s = 32'h0,
		p = 32'h0);
		wb(1'b1, slsu_pkg::REG_INSTR, ins, 4'hF);
		wb(1'b1, slsu_pkg::REG_BASE, b, 4'hF);
		wb(1'b1, slsu_pkg::REG_OFFSET, o, 4'hF);
		wb(1'b1, slsu_pkg::REG_SOURCE, s, 4'hF);
		wb(1'b1, slsu_pkg::REG_PC, p, 4'hF);
		wb(1'b1, slsu_pkg::REG_FLAGS, f, 4'hF);
		n_req = 0;
		tran_low = 1'b0;
		wb(1'b1, slsu_pkg::REG_CTRL, 32'h1, 4'hF);
		for (int k = 0; k < 100; k++) begin
			wb(1'b0, slsu_pkg::REG_STATUS, 32'h0, 4'hF);
			if (rdat[0] === 1'b0) break;
		end
		cmp({31'h0, rdat[0]}, 32'h0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		#2000000;
		mismatches++;
		conclude();
	end
	initial begin
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		// reset values, unmapped place, byte-enable merge
		rdc(slsu_pkg::REG_STATUS, 32'h0, '1);
		wb(1'b1, 6'h3C, 32'hFFFFFFFF, 4'hF);
		rdc(6'h3C, 32'h0, '1);
		wb(1'b1, slsu_pkg::REG_BASE, 32'h11111111, 4'hF);
		wb(1'b1, slsu_pkg::REG_BASE, 32'h0000AB00, 4'h2);
		rdc(slsu_pkg::REG_BASE, 32'h1111AB11, '1);
		// pre-indexed up, kept base, word load
		xfer(mk(6'b011001, 4'h1, 4'h3, 12'h010), 32'h40);
		rdc(slsu_pkg::REG_XADDR, 32'h50, '1);
		rdc(slsu_pkg::REG_RESULT, 32'h53525150, '1);
		rdc(slsu_pkg::REG_STATUS, 32'h02, 32'h3E);
		// pre-indexed down with write-back
		xfer(mk(6'b010011, 4'h1, 4'h3, 12'h008), 32'h80);
		rdc(slsu_pkg::REG_XADDR, 32'h78, '1);
		rdc(slsu_pkg::REG_NEWBASE, 32'h78, '1);
		// post-indexed: W=0 privileged, W=1 privileged, W=1 user
		for (int m = 0; m < 3; m++) begin
			lat <= 2'(m);
			xfer(mk(m == 0 ? 6'b001001 : 6'b001011, 4'h1, 4'h3, 12'h004), 32'h20, 32'h0,
				m == 2 ? 32'h0 : 32'h3);
			rdc(slsu_pkg::REG_XADDR, 32'h20, '1);
			rdc(slsu_pkg::REG_NEWBASE, 32'h24, '1);
			cmp({31'h0, tran_low}, {31'h0, m == 1});
		end
		// every shift type, amount 2 then amount 0
		for (int k = 0; k < 8; k++) begin
			xfer(mk(6'b111001, 4'h1, 4'h3, {k < 4 ? 5'd2 : 5'd0, 2'(k), 1'b0, 4'h2}), 32'h40,
				k == 0 ? 32'h4 : k < 4 ? 32'h40 : k == 6 ? 32'h80000000 : 32'h10 << k[0]);
			rdc(slsu_pkg::REG_XADDR, k == 5 ? 32'h40 : k == 6 ? 32'h3F : 32'h50,
				'1);
		end
		// every lane: byte load, then rotated word load
		for (int k = 0; k < 4; k++) begin
			lat <= 2'(k);
			xfer(mk(6'b011101, 4'h1, 4'h3, 12'(k)), 32'h60);
			rdc(slsu_pkg::REG_RESULT, 32'h60 + k, '1);
			xfer(mk(6'b011001, 4'h1, 4'h3, 12'(k)), 32'h60);
			rdc(slsu_pkg::REG_RESULT, (32'h63626160 >> 8 * k) | (32'h63626160 << (32 - 8 * k)),
				'1);
		end
		// byte store touches one lane, word store all
		xfer(mk(6'b011100, 4'h1, 4'h3, 12'h001), 32'h70, 32'h0, 32'h0, 32'hCAFE0055);
		cmp(mem.words[28], 32'h73725570);
		xfer(mk(6'b011000, 4'h1, 4'h3, 12'h0), 32'h74, 32'h0, 32'h0, 32'h12345678);
		cmp(mem.words[29], 32'h12345678);
		// program counter as base, offset and store source, and loaded
		xfer(mk(6'b011001, 4'hF, 4'h3, 12'h0), 32'h0, 32'h0, 32'hA8000003, 32'h0, 32'h100);
		rdc(slsu_pkg::REG_XADDR, 32'h108, '1);
		xfer(mk(6'b111001, 4'h1, 4'h3, 12'h00F), 32'h0, 32'h0, 32'h3, 32'h0, 32'h100);
		rdc(slsu_pkg::REG_XADDR, 32'h10B, '1);
		xfer(mk(6'b011000, 4'h1, 4'hF, 12'h0), 32'h78, 32'h0, 32'h48000002, 32'h0, 32'h100);
		cmp(mem.words[30], 32'h4800010E);
		xfer(mk(6'b011001, 4'h1, 4'hF, 12'h0), 32'h40, 32'h0, 32'h48000002);
		rdc(slsu_pkg::REG_STATUS, 32'h22, 32'h3E);
		rdc(slsu_pkg::REG_RESULT, 32'h4B424142, '1);
		rdc(slsu_pkg::REG_FLAGS, 32'h48000002, '1);
		// illegal address, then only the used address is checked
		xfer(mk(6'b011001, 4'h1, 4'h3, 12'h0), 32'h04000000);
		rdc(slsu_pkg::REG_STATUS, 32'h04, 32'h3C);
		cmp(32'(n_req), 32'h0);
		xfer(mk(6'b011001, 4'h1, 4'h3, 12'h0C0), 32'hFFFFFF40);
		rdc(slsu_pkg::REG_XADDR, 32'h0, '1);
		xfer(mk(6'b001001, 4'h1, 4'h3, 12'h008), 32'h03FFFFFC);
		rdc(slsu_pkg::REG_STATUS, 32'h12, 32'h3E);
		rdc(slsu_pkg::REG_NEWBASE, 32'h04000004, '1);
		// refused transfer leaves result and base alone
		abort_en <= 1'b1;
		xfer(mk(6'b010011, 4'h1, 4'h3, 12'h004), 32'h44);
		rdc(slsu_pkg::REG_STATUS, 32'h08, 32'h3C);
		rdc(slsu_pkg::REG_RESULT, 32'hFFFEFDFC, '1);
		rdc(slsu_pkg::REG_NEWBASE, 32'h04000004, '1);
		conclude();
	end
endmodule
bind slsu_top slsu_sva u_sva (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_done(mem_done),
	.abort_request(abort_request));
